// >>> rtl/cst_pkg.sv
// package: constants and types of the chassis status and thermal sequencer
// Contract
// - fan indicator green ok, red on fault
// - connection indicator green with session, else off
// - readiness indicator green ready, red not ready
// - fatal error blinks readiness yellow until power-cycle
// - boot: red, yellow initializing, then green
// - thermal indicator green within temperature limit
// - first over-temp: stay green, qualify one minute
// - persisting: yellow, suspend, reserve, halt traffic
// - yellow state monitors one more minute
// - still hot: reset used modules, go red
// - operator reset reinitializes, monitoring stays active
// - after reset restart sequence; cool means usable
// - remote login while hot raises thermal notice
// - rate indicator green 100M, yellow 10M
// - activity green traffic, yellow collision, else off
// - link green on pulse, red errors, else off
package cst_pkg;

   // ------------------------------------------------------------
   // sizes and timing
   // ------------------------------------------------------------
   localparam int unsigned FAN_N = 32'h4;
   localparam int unsigned MOD_N = 32'h8;
   localparam int unsigned ADDR_W = 32'h4;
   localparam logic [63:0] CLK_HZ = 64'h5F5E100;
   localparam logic [63:0] THERM_INTERVAL_S = 64'h3C;
   localparam logic [63:0] THERM_CYCLES = THERM_INTERVAL_S * CLK_HZ;
   localparam logic [63:0] BLINK_HZ = 64'h2;
   localparam logic [63:0] BLINK_CYCLES = CLK_HZ / (64'h2 * BLINK_HZ);

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hC;
   localparam int unsigned CTRL_OP_RESET_BIT = 32'h0;
   localparam int unsigned ST_TH_LSB = 32'h0;
   localparam int unsigned ST_BOOT_LSB = 32'h2;
   localparam int unsigned ST_FATAL_BIT = 32'h4;
   localparam int unsigned ST_HOT_BIT = 32'h5;
   localparam int unsigned IRQ_W = 32'h6;
   localparam int unsigned IRQ_QUAL = 32'h0;
   localparam int unsigned IRQ_SUSPEND = 32'h1;
   localparam int unsigned IRQ_MODRST = 32'h2;
   localparam int unsigned IRQ_FATAL = 32'h3;
   localparam int unsigned IRQ_NOTICE = 32'h4;
   localparam int unsigned IRQ_FAN = 32'h5;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CLR_OFF = 2'h0, CLR_GREEN = 2'h1, CLR_YELLOW = 2'h2, CLR_RED = 2'h3
   } cst_color_t;
   typedef enum logic [1:0] {
      TH_NORMAL = 2'h0, TH_QUAL = 2'h1, TH_SUSPEND = 2'h2, TH_RED = 2'h3
   } cst_th_state_t;
   typedef enum logic [1:0] {
      BOOT_HOLD = 2'h0, BOOT_INIT = 2'h1, BOOT_RUN = 2'h2
   } cst_boot_state_t;
   typedef struct packed {
      logic speed_100;
      logic activity;
      logic collision;
      logic duplex_full;
      logic link_ok;
      logic link_error;
   } cst_eth_t;
   typedef struct packed {
      logic [FAN_N-1:0] fan_fault;
      logic session_attached;
      logic chassis_ready;
      logic init_running;
      logic init_done;
      logic logins_enabled;
      logic fatal_error;
      logic over_temp;
      logic telnet_login;
      logic op_reset_req;
      logic [MOD_N-1:0] modules_in_use;
      cst_eth_t eth;
   } cst_pins_t;
   typedef struct packed {
      cst_color_t fan;
      cst_color_t conn;
      cst_color_t ready;
      cst_color_t thermal;
   } cst_front_t;
   typedef struct packed {
      cst_color_t rate;
      cst_color_t activity;
      cst_color_t duplex;
      cst_color_t link;
   } cst_back_t;

endpackage

// >>> rtl/cst_status_thermal.sv
// chassis status indicators, thermal sequencer and register slave
`timescale 1ns/1ps
module cst_status_thermal #(
   parameter logic [32:0] MINUTE_CYCLES = 33'(cst_pkg::THERM_CYCLES),
   parameter logic [24:0] BLINK_CYCLES = 25'(cst_pkg::BLINK_CYCLES)
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire cst_pkg::cst_pins_t pins,
   output cst_pkg::cst_front_t front_ind,
   output cst_pkg::cst_back_t back_ind,
   output logic suspend_test_ops,
   output logic reserve_all_modules,
   output logic halt_traffic,
   output logic [cst_pkg::MOD_N-1:0] module_reset,
   output logic thermal_notice,
   output logic irq,
   input wire logic [cst_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cst_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   cst_pkg::cst_pins_t sync1_r;
   cst_pkg::cst_pins_t pins_s;
   cst_pkg::cst_th_state_t th_state_r;
   cst_pkg::cst_th_state_t th_state_nxt;
   cst_pkg::cst_boot_state_t boot_state_r;
   cst_pkg::cst_front_t front_r;
   cst_pkg::cst_back_t back_r;
   logic [32:0] th_cnt_r;
   logic th_cnt_end;
   logic [24:0] blink_cnt_r;
   logic blink_r;
   logic fatal_r;
   logic op_req_d_r;
   logic fan_bad_d_r;
   logic notice_r;
   logic op_rst;
   logic sw_op_rst;
   logic [cst_pkg::MOD_N-1:0] mod_rst_r;
   logic susp_r;
   logic [cst_pkg::IRQ_W-1:0] irq_stat_r;
   logic [cst_pkg::IRQ_W-1:0] irq_mask_r;
   logic [cst_pkg::IRQ_W-1:0] irq_ev;
   logic [cst_pkg::IRQ_W-1:0] irq_clr;
   logic aw_hold_r;
   logic w_hold_r;
   logic [cst_pkg::ADDR_W-1:0] awaddr_r;
   logic [31:0] wdata_r;
   logic wstrb0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic wr_go;

   function automatic logic reg_hit(input logic [cst_pkg::ADDR_W-1:0] a,
                                    input logic [cst_pkg::ADDR_W-1:0] off);
      reg_hit = (a[cst_pkg::ADDR_W-1:2] == off[cst_pkg::ADDR_W-1:2]);
   endfunction

   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   // every pin is asynchronous to aclk, so all pass two stages
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_r <= '0;
         pins_s <= '0;
      end
      else
      begin
         sync1_r <= pins;
         pins_s <= sync1_r;
      end
   end

   // ------------------------------------------------------------
   // operator reset and fatal latch
   // ------------------------------------------------------------
   assign sw_op_rst = wr_go && reg_hit(awaddr_r, cst_pkg::OFF_CTRL) && wstrb0_r
                      && wdata_r[cst_pkg::CTRL_OP_RESET_BIT];
   assign op_rst = (pins_s.op_reset_req && !op_req_d_r) || sw_op_rst;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         op_req_d_r <= 1'b0;
         fan_bad_d_r <= 1'b0;
         fatal_r <= 1'b0;
      end
      else
      begin
         op_req_d_r <= pins_s.op_reset_req;
         fan_bad_d_r <= |pins_s.fan_fault;
         if (pins_s.fatal_error)
            fatal_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // boot sequence
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         boot_state_r <= cst_pkg::BOOT_HOLD;
      else if (op_rst)
         boot_state_r <= cst_pkg::BOOT_HOLD;
      else
      begin
         unique case (boot_state_r)
            cst_pkg::BOOT_HOLD:
               if (pins_s.init_running)
                  boot_state_r <= cst_pkg::BOOT_INIT;
            cst_pkg::BOOT_INIT:
               if (pins_s.init_done && pins_s.logins_enabled)
                  boot_state_r <= cst_pkg::BOOT_RUN;
            cst_pkg::BOOT_RUN:
               boot_state_r <= cst_pkg::BOOT_RUN;
            default:
               boot_state_r <= cst_pkg::BOOT_HOLD;
         endcase
      end
   end

   // ------------------------------------------------------------
   // thermal sequencer
   // ------------------------------------------------------------
   assign th_cnt_end = (th_cnt_r == MINUTE_CYCLES - 33'h1);

   always_comb
   begin
      th_state_nxt = th_state_r;
      unique case (th_state_r)
         cst_pkg::TH_NORMAL:
            if (pins_s.over_temp)
               th_state_nxt = cst_pkg::TH_QUAL;
         cst_pkg::TH_QUAL:
            if (!pins_s.over_temp)
               th_state_nxt = cst_pkg::TH_NORMAL;
            else if (th_cnt_end)
               th_state_nxt = cst_pkg::TH_SUSPEND;
         cst_pkg::TH_SUSPEND:
            if (th_cnt_end && pins_s.over_temp)
               th_state_nxt = cst_pkg::TH_RED;
         cst_pkg::TH_RED:
            th_state_nxt = cst_pkg::TH_RED;
      endcase
      if (op_rst)
         th_state_nxt = cst_pkg::TH_NORMAL;
   end

   // suspended states hold until an operator reset; a dip under the limit
   // alone does not release reserved modules
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         th_state_r <= cst_pkg::TH_NORMAL;
         th_cnt_r <= 33'h0;
      end
      else
      begin
         th_state_r <= th_state_nxt;
         if (th_state_nxt != th_state_r || op_rst || th_cnt_end)
            th_cnt_r <= 33'h0;
         else if (th_state_r == cst_pkg::TH_QUAL || th_state_r == cst_pkg::TH_SUSPEND)
            th_cnt_r <= th_cnt_r + 33'h1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         susp_r <= 1'b0;
         mod_rst_r <= '0;
         notice_r <= 1'b0;
      end
      else
      begin
         susp_r <= (th_state_r == cst_pkg::TH_SUSPEND) || (th_state_r == cst_pkg::TH_RED);
         if (th_state_r == cst_pkg::TH_SUSPEND && th_state_nxt == cst_pkg::TH_RED)
            mod_rst_r <= pins_s.modules_in_use;
         else
            mod_rst_r <= '0;
         notice_r <= pins_s.telnet_login && pins_s.over_temp;
      end
   end

   // ------------------------------------------------------------
   // blink divider
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         blink_cnt_r <= 25'h0;
         blink_r <= 1'b0;
      end
      else if (blink_cnt_r == BLINK_CYCLES - 25'h1)
      begin
         blink_cnt_r <= 25'h0;
         blink_r <= !blink_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + 25'h1;
   end

   // ------------------------------------------------------------
   // indicators
   // ------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         front_r <= {cst_pkg::CLR_GREEN, cst_pkg::CLR_OFF, cst_pkg::CLR_RED,
                     cst_pkg::CLR_GREEN};
         back_r <= {cst_pkg::CLR_YELLOW, cst_pkg::CLR_OFF, cst_pkg::CLR_YELLOW,
                    cst_pkg::CLR_OFF};
      end
      else
      begin
         front_r.fan <= (|pins_s.fan_fault) ? cst_pkg::CLR_RED : cst_pkg::CLR_GREEN;
         front_r.conn <= pins_s.session_attached ? cst_pkg::CLR_GREEN : cst_pkg::CLR_OFF;
         if (fatal_r || pins_s.fatal_error)
            front_r.ready <= blink_r ? cst_pkg::CLR_YELLOW : cst_pkg::CLR_OFF;
         else if (boot_state_r == cst_pkg::BOOT_INIT)
            front_r.ready <= cst_pkg::CLR_YELLOW;
         else if (boot_state_r == cst_pkg::BOOT_RUN && pins_s.chassis_ready)
            front_r.ready <= cst_pkg::CLR_GREEN;
         else
            front_r.ready <= cst_pkg::CLR_RED;
         unique case (th_state_r)
            cst_pkg::TH_NORMAL, cst_pkg::TH_QUAL: front_r.thermal <= cst_pkg::CLR_GREEN;
            cst_pkg::TH_SUSPEND: front_r.thermal <= cst_pkg::CLR_YELLOW;
            cst_pkg::TH_RED: front_r.thermal <= cst_pkg::CLR_RED;
         endcase
         back_r.rate <= pins_s.eth.speed_100 ? cst_pkg::CLR_GREEN : cst_pkg::CLR_YELLOW;
         back_r.activity <= pins_s.eth.collision ? cst_pkg::CLR_YELLOW :
                            pins_s.eth.activity ? cst_pkg::CLR_GREEN : cst_pkg::CLR_OFF;
         back_r.duplex <= pins_s.eth.duplex_full ? cst_pkg::CLR_GREEN : cst_pkg::CLR_YELLOW;
         back_r.link <= pins_s.eth.link_error ? cst_pkg::CLR_RED :
                        pins_s.eth.link_ok ? cst_pkg::CLR_GREEN : cst_pkg::CLR_OFF;
      end
   end

   // ------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------
   assign irq_ev[cst_pkg::IRQ_QUAL] = (th_state_r == cst_pkg::TH_NORMAL)
                                      && (th_state_nxt == cst_pkg::TH_QUAL);
   assign irq_ev[cst_pkg::IRQ_SUSPEND] = (th_state_r == cst_pkg::TH_QUAL)
                                         && (th_state_nxt == cst_pkg::TH_SUSPEND);
   assign irq_ev[cst_pkg::IRQ_MODRST] = (th_state_r == cst_pkg::TH_SUSPEND)
                                        && (th_state_nxt == cst_pkg::TH_RED);
   assign irq_ev[cst_pkg::IRQ_FATAL] = pins_s.fatal_error && !fatal_r;
   assign irq_ev[cst_pkg::IRQ_NOTICE] = pins_s.telnet_login && pins_s.over_temp && !notice_r;
   assign irq_ev[cst_pkg::IRQ_FAN] = (|pins_s.fan_fault) && !fan_bad_d_r;
   assign irq_clr = (s_axi_arvalid && s_axi_arready
                     && reg_hit(s_axi_araddr, cst_pkg::OFF_IRQ_STAT)) ? '1 : '0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_stat_r <= '0;
      else
         // an event in the clearing cycle survives
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_mask_r <= cst_pkg::IRQ_MASK_RST;
      else if (wr_go && reg_hit(awaddr_r, cst_pkg::OFF_IRQ_MASK) && wstrb0_r)
         irq_mask_r <= wdata_r[cst_pkg::IRQ_W-1:0];
   end

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   // address and data may come in either order; both are parked first
   assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 32'h0;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= cst_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (reg_hit(awaddr_r, cst_pkg::OFF_CTRL)
                        || reg_hit(awaddr_r, cst_pkg::OFF_IRQ_MASK)
                        || reg_hit(awaddr_r, cst_pkg::OFF_STATUS)
                        || reg_hit(awaddr_r, cst_pkg::OFF_IRQ_STAT))
                       ? cst_pkg::RESP_OKAY : cst_pkg::RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
            bvalid_r <= 1'b0;
      end
   end

   always_comb
   begin
      rd_mux = 32'h0;
      rd_hit = 1'b1;
      if (reg_hit(s_axi_araddr, cst_pkg::OFF_STATUS))
      begin
         rd_mux[cst_pkg::ST_TH_LSB +: 2] = th_state_r;
         rd_mux[cst_pkg::ST_BOOT_LSB +: 2] = boot_state_r;
         rd_mux[cst_pkg::ST_FATAL_BIT] = fatal_r;
         rd_mux[cst_pkg::ST_HOT_BIT] = pins_s.over_temp;
      end
      else if (reg_hit(s_axi_araddr, cst_pkg::OFF_IRQ_STAT))
         rd_mux[cst_pkg::IRQ_W-1:0] = irq_stat_r;
      else if (reg_hit(s_axi_araddr, cst_pkg::OFF_IRQ_MASK))
         rd_mux[cst_pkg::IRQ_W-1:0] = irq_mask_r;
      else if (!reg_hit(s_axi_araddr, cst_pkg::OFF_CTRL))
         rd_hit = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= cst_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_mux;
         rresp_r <= rd_hit ? cst_pkg::RESP_OKAY : cst_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_r <= 1'b0;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign front_ind = front_r;
   assign back_ind = back_r;
   assign suspend_test_ops = susp_r;
   assign reserve_all_modules = susp_r;
   assign halt_traffic = susp_r;
   assign module_reset = mod_rst_r;
   assign thermal_notice = notice_r;
   assign irq = |(irq_stat_r & irq_mask_r);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_fan_red;
      @(posedge aclk) disable iff (!aresetn)
      (|pins_s.fan_fault) |=> front_r.fan == cst_pkg::CLR_RED;
   endproperty
   a_fan_red: assert property (p_fan_red) else $error("fan fault not red");

   property p_conn_off;
      @(posedge aclk) disable iff (!aresetn)
      !pins_s.session_attached |=> front_r.conn == cst_pkg::CLR_OFF;
   endproperty
   a_conn_off: assert property (p_conn_off) else $error("conn lit with no session");

   property p_fatal_blink;
      @(posedge aclk) disable iff (!aresetn)
      fatal_r |=> fatal_r && front_r.ready != cst_pkg::CLR_GREEN
                  && front_r.ready != cst_pkg::CLR_RED;
   endproperty
   a_fatal_blink: assert property (p_fatal_blink) else $error("fatal not held");

   property p_qual_green;
      @(posedge aclk) disable iff (!aresetn)
      th_state_r == cst_pkg::TH_QUAL |=> front_r.thermal == cst_pkg::CLR_GREEN;
   endproperty
   a_qual_green: assert property (p_qual_green) else $error("qualify not green");

   property p_suspend;
      @(posedge aclk) disable iff (!aresetn)
      (th_state_r == cst_pkg::TH_QUAL && th_cnt_end && pins_s.over_temp && !op_rst)
      |=> th_state_r == cst_pkg::TH_SUSPEND ##1 susp_r && halt_traffic
          && front_r.thermal == cst_pkg::CLR_YELLOW;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend not entered");

   property p_red;
      @(posedge aclk) disable iff (!aresetn)
      (th_state_r == cst_pkg::TH_SUSPEND && th_cnt_end && pins_s.over_temp && !op_rst)
      |=> th_state_r == cst_pkg::TH_RED && mod_rst_r == $past(pins_s.modules_in_use);
   endproperty
   a_red: assert property (p_red) else $error("module reset missing");

   property p_restart;
      @(posedge aclk) disable iff (!aresetn)
      op_rst |=> th_state_r == cst_pkg::TH_NORMAL && th_cnt_r == 33'h0
                 && boot_state_r == cst_pkg::BOOT_HOLD;
   endproperty
   a_restart: assert property (p_restart) else $error("operator reset ignored");

   property p_activity;
      @(posedge aclk) disable iff (!aresetn)
      pins_s.eth.collision |=> back_r.activity == cst_pkg::CLR_YELLOW;
   endproperty
   a_activity: assert property (p_activity) else $error("collision not yellow");

   property p_link;
      @(posedge aclk) disable iff (!aresetn)
      (pins_s.eth.link_ok && !pins_s.eth.link_error) |=> back_r.link == cst_pkg::CLR_GREEN;
   endproperty
   a_link: assert property (p_link) else $error("link not green");

   property p_blink;
      @(posedge aclk) disable iff (!aresetn)
      (blink_cnt_r == BLINK_CYCLES - 25'h1) |=> blink_r != $past(blink_r);
   endproperty
   a_blink: assert property (p_blink) else $error("blink did not toggle");

endmodule // cst_status_thermal

// >>> verification/cst_env_model.sv
// far-side model: sensor, operator and host levels onto the pins
`timescale 1ns/1ps
module cst_env_model (
   input wire logic aclk,
   input wire cst_pkg::cst_pins_t want,
   output cst_pkg::cst_pins_t pins
);
   // ----
   // pins
   // ----
   // every pin level, one cycle after want
   always_ff @(posedge aclk)
   begin
      pins <= want;
   end
endmodule // cst_env_model

// >>> verification/cst_status_thermal_bench.sv
// self-checking bench of the chassis status and thermal sequencer
`timescale 1ns/1ps
module cst_status_thermal_bench;
   logic aclk = 1'b0, aresetn = 1'b0;
   cst_pkg::cst_pins_t want = '0, pins;
   cst_pkg::cst_front_t front_ind;
   cst_pkg::cst_back_t back_ind;
   logic suspend_test_ops, reserve_all_modules, halt_traffic, thermal_notice, irq;
   logic [7:0] module_reset, seen = 8'h00;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_total = 0, checks = 0, cyc = 0, seed = 17;
   always #5 aclk = ~aclk;
   cst_env_model ENV (.aclk(aclk), .want(want), .pins(pins));
   // short minute keeps the run brief
   cst_status_thermal #(.MINUTE_CYCLES(33'h14), .BLINK_CYCLES(25'h4)) DUT (.*);
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      cmp(s_axi_bresp, cst_pkg::RESP_OKAY);
   endtask
   task automatic rdr(input logic [3:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      rd = s_axi_rdata;
      cmp(s_axi_rresp, cst_pkg::RESP_OKAY);
      s_axi_rready <= 1'b0;
   endtask
   // collision beats traffic, error beats link
   function automatic logic [7:0] exp_back(cst_pkg::cst_eth_t e);
      exp_back = {e.speed_100 ? 2'h1 : 2'h2, e.collision ? 2'h2 : {1'b0, e.activity},
         e.duplex_full ? 2'h1 : 2'h2, e.link_error ? 2'h3 : {1'b0, e.link_ok}};
   endfunction
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (module_reset !== 8'h00) seen <= module_reset;
      if (cyc == 2000)
      begin
         err_total++;
         complete_run;
      end
   end
   initial
   begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      cmp({front_ind, back_ind}, 16'h4D88);
      repeat (8)
      begin
         want.eth <= 6'($random(seed));
         want.fan_fault <= 4'($random(seed));
         want.session_attached <= 1'($random(seed));
         repeat (6) @(posedge aclk);
         cmp(back_ind, exp_back(want.eth));
         cmp(front_ind.fan, (want.fan_fault != 4'h0) ? 2'h3 : 2'h1);
         cmp(front_ind.conn, {1'b0, want.session_attached});
      end
      want.init_running <= 1'b1;
      repeat (6) @(posedge aclk);
      cmp(front_ind.ready, 2'h2);
      want <= '{init_done: 1'b1, logins_enabled: 1'b1, chassis_ready: 1'b1, default: '0};
      repeat (6) @(posedge aclk);
      cmp(front_ind.ready, 2'h1);
      $display("indicator test done");
      wr(cst_pkg::OFF_IRQ_MASK, 32'h3F);
      rdr(cst_pkg::OFF_IRQ_STAT);
      want.modules_in_use <= 8'hA5;
      want.over_temp <= 1'b1;
      repeat (10) @(posedge aclk);
      rdr(cst_pkg::OFF_STATUS);
      cmp({rd[1:0], front_ind.thermal, suspend_test_ops, irq}, 6'b010101);
      repeat (16) @(posedge aclk);
      cmp({front_ind.thermal, suspend_test_ops, reserve_all_modules, halt_traffic}, 5'h17);
      repeat (22) @(posedge aclk);
      cmp({front_ind.thermal, seen}, {2'h3, 8'hA5});
      rdr(cst_pkg::OFF_IRQ_STAT);
      cmp(rd & 32'h7, 32'h7);
      rdr(cst_pkg::OFF_IRQ_STAT);
      cmp({rd, irq}, 33'h0);
      want.telnet_login <= 1'b1;
      repeat (6) @(posedge aclk);
      cmp(thermal_notice, 1'b1);
      wr(cst_pkg::OFF_CTRL, 32'h1);
      repeat (4) @(posedge aclk);
      rdr(cst_pkg::OFF_STATUS);
      cmp({rd[1:0], suspend_test_ops}, 3'b010);
      want.over_temp <= 1'b0;
      repeat (6) @(posedge aclk);
      cmp({front_ind.thermal, thermal_notice}, 3'b010);
      // operator reset from the pin drops a running chassis back to red
      want.init_running <= 1'b1;
      repeat (8) @(posedge aclk);
      cmp(front_ind.ready, 2'h1);
      want.op_reset_req <= 1'b1;
      want.init_running <= 1'b0;
      repeat (6) @(posedge aclk);
      cmp(front_ind.ready, 2'h3);
      $display("thermal test done");
      want.fatal_error <= 1'b1;
      rd = 32'h0;
      repeat (24)
      begin
         @(posedge aclk);
         rd = rd | {front_ind.ready == 2'h2, front_ind.ready == 2'h0};
      end
      cmp(rd, 32'h3);
      $display("fatal test done");
      complete_run;
   end
endmodule // cst_status_thermal_bench
